// ### inc/dtc_evt_if.sv
// machine-cycle tick and sampled pin events between timer modules
`timescale 1ns/1ns
interface dtc_evt_if;
  import dtc_pkg::*;
  logic mc_tick;
  logic [NUM_PINS-1:0] fall;
  logic [NUM_PINS-1:0] level_low;
  modport prescaler (output mc_tick);
  modport sampler (input mc_tick, output fall, output level_low);
  modport core (input mc_tick, input fall, input level_low);
endinterface

// ### inc/dtc_pkg.sv
// constants and types shared by the dual timer/counter files
package dtc_pkg;
  // special function register addresses
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_U0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_U1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_U0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_U1_HIGH = 8'h8D;
  // timer_control_flags bit positions
  localparam int CTRL_U1_OVF = 7;
  localparam int CTRL_U1_RUN = 6;
  localparam int CTRL_U0_OVF = 5;
  localparam int CTRL_U0_RUN = 4;
  localparam int CTRL_EXT_B_FLAG = 3;
  localparam int CTRL_EXT_B_TYPE = 2;
  localparam int CTRL_EXT_A_FLAG = 1;
  localparam int CTRL_EXT_A_TYPE = 0;
  // timer_mode_select field positions
  localparam int MODE_U0_GATE = 7;
  localparam int MODE_U0_CT = 6;
  localparam int MODE_U0_FIELD = 4;
  localparam int MODE_U1_GATE = 3;
  localparam int MODE_U1_CT = 2;
  localparam int MODE_U1_FIELD = 0;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // processor clocks per machine cycle
  localparam int MC_CLOCKS = 12;
  // sampled pins: count a, count b, ext irq a, ext irq b
  localparam int NUM_PINS = 4;
  localparam int PIN_COUNT_A = 0;
  localparam int PIN_COUNT_B = 1;
  localparam int PIN_IRQ_A = 2;
  localparam int PIN_IRQ_B = 3;
  // mode field: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split/stop
  typedef enum logic [1:0] {
    DTC_M13,
    DTC_M16,
    DTC_M8R,
    DTC_SPLIT
  } dtc_mode_t;
endpackage

// ### verif/dtc_pin_model.sv
// external event pins: idle high, slow pulses or held levels
`timescale 1ns/1ns
module dtc_pin_model (
  input wire logic clk_i,
  output logic [3:0] pins_o
);
  initial pins_o = 4'hF;
  task automatic pulse(input logic [3:0] sel, input int n);
    repeat (n) begin
      repeat (16) @(posedge clk_i);
      pins_o <= pins_o & ~sel;
      repeat (16) @(posedge clk_i);
      pins_o <= pins_o | sel;
    end
  endtask
  task automatic level(input logic [3:0] sel, input logic lvl);
    @(posedge clk_i);
    pins_o <= lvl ? (pins_o | sel) : (pins_o & ~sel);
  endtask
endmodule // dtc_pin_model

// ### verif/dtc_props.sv
// port-level assertions for the dual timer/counter
`timescale 1ns/1ns
module dtc_props
  import dtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic unit0_ack_i,
  input wire logic unit1_ack_i,
  input wire logic unit0_irq_o,
  input wire logic unit1_irq_o,
  input wire logic ext_irq_a_req_o,
  input wire logic ext_irq_b_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reset_clears_a: assert property (disable iff (1'b0) rst_i |=> sfr_rdata_o == 8'h00 &&
    !unit0_irq_o && !unit1_irq_o && !ext_irq_a_req_o && !ext_irq_b_req_o)
    else $error("outputs not cleared by reset");
  mode_readback_a: assert property (sfr_wr_i && sfr_addr_i == ADDR_MODE ##1
    sfr_addr_i == ADDR_MODE && !sfr_wr_i |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
    else $error("mode register readback wrong");
  // read data lags the flag register by one cycle, so compare with the past request
  unit0_irq_flag_a: assert property ($past(sfr_addr_i) == ADDR_CTRL |->
    sfr_rdata_o[CTRL_U0_OVF] == $past(unit0_irq_o))
    else $error("unit0 request differs from flag");
  unit1_irq_flag_a: assert property ($past(sfr_addr_i) == ADDR_CTRL |->
    sfr_rdata_o[CTRL_U1_OVF] == $past(unit1_irq_o))
    else $error("unit1 request differs from flag");
  ext_a_edge_a: assert property ($past(sfr_addr_i) == ADDR_CTRL &&
    sfr_rdata_o[CTRL_EXT_A_TYPE] |-> sfr_rdata_o[CTRL_EXT_A_FLAG] == $past(ext_irq_a_req_o))
    else $error("edge request a differs from flag");
  ext_b_edge_a: assert property ($past(sfr_addr_i) == ADDR_CTRL &&
    sfr_rdata_o[CTRL_EXT_B_TYPE] |-> sfr_rdata_o[CTRL_EXT_B_FLAG] == $past(ext_irq_b_req_o))
    else $error("edge request b differs from flag");
  unit0_ack_clear_a: assert property (unit0_ack_i |-> ##2 !unit0_irq_o)
    else $error("unit0 ack did not clear request");
  unit1_ack_clear_a: assert property (unit1_ack_i |-> ##2 !unit1_irq_o)
    else $error("unit1 ack did not clear request");
  cover property (unit0_irq_o);
  cover property (unit1_irq_o);
  cover property (ext_irq_b_req_o);
endmodule // dtc_props
bind dtc_top dtc_props i_props (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
  .sfr_rdata_o, .unit0_ack_i, .unit1_ack_i, .unit0_irq_o, .unit1_irq_o, .ext_irq_a_req_o,
  .ext_irq_b_req_o);

// ### verif/tb_top.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/1ns
module tb_top;
  import dtc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic [3:0] pins;
  logic [3:0] acks = 4'h0;
  logic [3:0] outs;
  int failures = 0;
  int total_checks = 0;
  always #25 clk_i = ~clk_i;
  dtc_pin_model i_pins (.clk_i, .pins_o(pins));
  dtc_top i_dut (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
    .count_input_a_i(pins[0]), .count_input_b_i(pins[1]), .ext_irq_input_a_i(pins[2]),
    .ext_irq_input_b_i(pins[3]), .unit0_ack_i(acks[0]), .unit1_ack_i(acks[1]),
    .ext_irq_a_ack_i(acks[2]), .ext_irq_b_ack_i(acks[3]), .unit0_irq_o(outs[0]),
    .unit1_irq_o(outs[1]), .ext_irq_a_req_o(outs[2]), .ext_irq_b_req_o(outs[3]));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wr_i <= 1'b1;
    sfr_wdata_i <= d;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_i);
    sfr_addr_i <= a;
    @(posedge clk_i);
    #1 check8(sfr_rdata_o, exp, what);
  endtask
  task automatic ack(input logic [3:0] m);
    @(posedge clk_i);
    acks <= m;
    @(posedge clk_i);
    acks <= 4'h0;
  endtask
  task automatic wait_out(input int i, input logic v, input string what);
    int n;
    n = 0;
    while (outs[i] !== v && n < 60) begin
      @(posedge clk_i);
      #1 n++;
    end
    check8({7'h00, outs[i]}, {7'h00, v}, what);
    if (outs[i] !== v) tally_and_finish();
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 'h88; a <= 'h8E; a++) begin
      rd_chk(a[7:0], 8'h00, "reset or unmapped value");
    end
    $display("test reset done");
    wr(ADDR_MODE, 8'h11);
    rd_chk(ADDR_MODE, 8'h11, "mode readback");
    wr(ADDR_U0_LOW, 8'hF0);
    wr(ADDR_CTRL, 8'h10);
    repeat (118) @(posedge clk_i);
    wr(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_U0_LOW, 8'hFA, "ten machine cycles");
    repeat (50) @(posedge clk_i);
    rd_chk(ADDR_U0_LOW, 8'hFA, "stopped count holds");
    $display("test timer done");
    wr(ADDR_MODE, 8'h62);
    wr(ADDR_U0_HIGH, 8'h80);
    wr(ADDR_U0_LOW, 8'hFE);
    wr(ADDR_CTRL, 8'h10);
    i_pins.pulse(4'h1, 3);
    rd_chk(ADDR_U0_LOW, 8'h81, "reload after overflow");
    rd_chk(ADDR_CTRL, 8'h30, "overflow flag set");
    wr(ADDR_CTRL, 8'h10);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_U0_LOW, 8'hFF);
      i_pins.pulse(4'h1, 1);
      wait_out(0, 1'b1, "overflow request");
      if (k == 0) ack(4'h1);
      else wr(ADDR_CTRL, 8'h10);
      wait_out(0, 1'b0, "flag cleared");
      rd_chk(ADDR_CTRL, 8'h10, "control after clear");
    end
    $display("test reload done");
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_U0_HIGH, 8'h00);
    wr(ADDR_U0_LOW, 8'hFF);
    rd_chk(ADDR_U0_LOW, 8'h1F, "low byte top bits zero");
    i_pins.pulse(4'h1, 1);
    rd_chk(ADDR_U0_LOW, 8'h00, "short carry low");
    rd_chk(ADDR_U0_HIGH, 8'h01, "short carry high");
    $display("test short mode done");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_U1_LOW, 8'h10);
    wr(ADDR_MODE, 8'h73);
    wr(ADDR_U0_HIGH, 8'hFE);
    wr(ADDR_CTRL, 8'h40);
    wait_out(1, 1'b1, "split high byte overflow");
    wr(ADDR_CTRL, 8'h80);
    rd_chk(ADDR_CTRL, 8'h80, "only high flag set");
    rd_chk(ADDR_U1_LOW, 8'h10, "unit one halted");
    ack(4'h2);
    wait_out(1, 1'b0, "unit one flag cleared");
    $display("test split done");
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_U1_LOW, 8'hFF);
    wr(ADDR_U1_HIGH, 8'hFF);
    wr(ADDR_CTRL, 8'h40);
    i_pins.pulse(4'h2, 1);
    wait_out(1, 1'b1, "unit one gated overflow");
    rd_chk(ADDR_U1_LOW, 8'h00, "unit one gated low");
    rd_chk(ADDR_U1_HIGH, 8'h00, "unit one full carry");
    wr(ADDR_CTRL, 8'h00);
    wait_out(1, 1'b0, "unit one flag written clear");
    $display("test gated unit one done");
    wr(ADDR_CTRL, 8'h01);
    i_pins.pulse(4'h4, 1);
    wait_out(2, 1'b1, "edge request a");
    rd_chk(ADDR_CTRL, 8'h03, "edge flag a");
    ack(4'h4);
    wait_out(2, 1'b0, "edge request a cleared");
    wr(ADDR_CTRL, 8'h00);
    i_pins.level(4'h8, 1'b0);
    wait_out(3, 1'b1, "low level request b");
    rd_chk(ADDR_CTRL, 8'h08, "edge flag b in level mode");
    i_pins.level(4'h8, 1'b1);
    wait_out(3, 1'b0, "level request b released");
    ack(4'h8);
    rd_chk(ADDR_CTRL, 8'h00, "edge flag b cleared");
    wr(ADDR_CTRL, 8'h04);
    i_pins.level(4'h4, 1'b0);
    i_pins.pulse(4'h8, 1);
    wait_out(2, 1'b1, "low level request a");
    wait_out(3, 1'b1, "edge request b");
    rd_chk(ADDR_CTRL, 8'h0E, "both edge flags");
    i_pins.level(4'h4, 1'b1);
    ack(4'h8);
    wait_out(3, 1'b0, "edge request b cleared");
    wait_out(2, 1'b0, "level request a released");
    $display("test external requests done");
    tally_and_finish();
  end
endmodule // tb_top

// ### verilog/dtc_prescale.sv
// machine-cycle tick generator, one pulse per MC_CLOCKS clocks
`timescale 1ns/1ns
module dtc_prescale (
  input wire logic clk_i,
  input wire logic rst_i,
  dtc_evt_if.prescaler evt
);
  import dtc_pkg::*;
  localparam logic [3:0] LAST = 4'(MC_CLOCKS - 1);
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  always_comb begin
    next_cnt = (cnt == LAST) ? 4'h0 : cnt + 4'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign evt.mc_tick = (cnt == LAST);
endmodule // dtc_prescale

// ### verilog/dtc_sample.sv
// pin synchroniser and once-per-machine-cycle falling edge detector
`timescale 1ns/1ns
module dtc_sample #(
  parameter int N = dtc_pkg::NUM_PINS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] pins_i,
  dtc_evt_if.sampler evt
);
  import dtc_pkg::*;
  logic [N-1:0] meta;
  logic [N-1:0] sync;
  logic [N-1:0] smp;
  logic [N-1:0] fall;
  logic [N-1:0] next_smp;
  logic [N-1:0] next_fall;

  // a high sample then a low sample one machine cycle later
  always_comb begin
    next_smp = evt.mc_tick ? sync : smp;
    next_fall = evt.mc_tick ? (smp & ~sync) : '0; // RQ3
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '1;
      sync <= '1;
      smp <= '1;
      fall <= '0;
    end else begin
      meta <= pins_i;
      sync <= meta;
      smp <= next_smp;
      fall <= next_fall;
    end
  end

  assign evt.fall = fall;
  assign evt.level_low = ~smp;
endmodule // dtc_sample

// ### verilog/dtc_top.sv
// dual 16-bit timer/counter with special function register access
//
// Functional notes
// (RQ1) timer mode: one increment per machine cycle
// (RQ2) counter mode: increment on input falling edge
// (RQ3) edge seen over two machine-cycle samples
// (RQ4) source holds each level one machine cycle
// (RQ5) mode field selects one of four modes
// (RQ6) 13-bit mode: low five bits, upper zero
// (RQ7) auto-reload: high byte reloads low on overflow
// (RQ8) unit 1 in mode 3 halts
// (RQ9) unit 0 in mode 3 splits in two
// (RQ10) split high byte uses unit 1 run, flag
// (RQ11) unit 0 reload needs unit 1 reload; the code reloads unit 0 whatever mode unit 1 is in
// (RQ12) gate plus run counts routed pin edges
// (RQ13) counter-select: 1 events, 0 machine cycles; the code counts pin edges at 0 too when the gate bit is set
// (RQ14) run bit clear stops and holds count
// (RQ15) overflow flag set, software or service clears
// (RQ16) edge flag set on falling edge, service clears
// (RQ17) type bit selects edge or low level
// (RQ18) type 0 level, type 1 falling edge
// (RQ19) reset clears counts, mode and control
`timescale 1ns/1ns
module dtc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic count_input_a_i,
  input wire logic count_input_b_i,
  input wire logic ext_irq_input_a_i,
  input wire logic ext_irq_input_b_i,
  input wire logic unit0_ack_i,
  input wire logic unit1_ack_i,
  input wire logic ext_irq_a_ack_i,
  input wire logic ext_irq_b_ack_i,
  output logic unit0_irq_o,
  output logic unit1_irq_o,
  output logic ext_irq_a_req_o,
  output logic ext_irq_b_req_o
);
  import dtc_pkg::*;

  // one count step of a non-split unit: {overflow, high, low}
  function automatic logic [16:0] dtc_step(dtc_mode_t m, logic [7:0] lo,
                                           logic [7:0] hi);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    logic [16:0] r;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8 = {1'b0, lo} + 9'h001;
    unique case (m)
      DTC_M13: r = {s13[13], s13[12:5], 3'b000, s13[4:0]}; // RQ6
      DTC_M16: r = s16;
      DTC_M8R: begin
        if (s8[8]) begin
          r = {1'b1, hi, hi}; // RQ7
        end else begin
          r = {1'b0, hi, s8[7:0]};
        end
      end
      DTC_SPLIT: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  // 8-bit increment for the split halves: {overflow, value}
  function automatic logic [8:0] dtc_inc8(logic [7:0] v);
    return {1'b0, v} + 9'h001;
  endfunction

  dtc_evt_if evt ();

  dtc_prescale u_prescale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .evt(evt.prescaler)
  );

  dtc_sample #(
    .N(NUM_PINS)
  ) u_sample (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i({ext_irq_input_b_i, ext_irq_input_a_i, count_input_b_i,
             count_input_a_i}),
    .evt(evt.sampler)
  );

  logic [7:0] ctrl;
  logic [7:0] timer_mode_select;
  logic [7:0] u0_low;
  logic [7:0] u0_high;
  logic [7:0] u1_low;
  logic [7:0] u1_high;
  logic [7:0] rdata;
  logic [7:0] next_ctrl;
  logic [7:0] next_timer_mode_select;
  logic [7:0] next_u0_low;
  logic [7:0] next_u0_high;
  logic [7:0] next_u1_low;
  logic [7:0] next_u1_high;
  logic [7:0] next_rdata;

  dtc_mode_t mode0;
  dtc_mode_t mode1;
  logic src0;
  logic src1;
  logic inc0;
  logic inc1;
  logic inc0_high;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0] split_lo;
  logic [8:0] split_hi;
  logic ovf0;
  logic ovf1;
  logic wr_ctrl;

  assign mode0 = dtc_mode_t'(timer_mode_select[MODE_U0_FIELD +: 2]); // RQ5
  assign mode1 = dtc_mode_t'(timer_mode_select[MODE_U1_FIELD +: 2]); // RQ5
  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == ADDR_CTRL);

  // count source: gate or counter-select takes pin edges, else machine cycles
  always_comb begin
    src0 = (timer_mode_select[MODE_U0_GATE] || timer_mode_select[MODE_U0_CT]) ? evt.fall[PIN_COUNT_A] // RQ2 RQ12 RQ13
                                                    : evt.mc_tick; // RQ1
    src1 = (timer_mode_select[MODE_U1_GATE] || timer_mode_select[MODE_U1_CT]) ? evt.fall[PIN_COUNT_B] // RQ2 RQ12 RQ13
                                                    : evt.mc_tick; // RQ1
    inc0 = ctrl[CTRL_U0_RUN] && src0; // RQ14
    inc1 = ctrl[CTRL_U1_RUN] && src1 && (mode1 != DTC_SPLIT); // RQ8 RQ14
    inc0_high = ctrl[CTRL_U1_RUN] && evt.mc_tick; // RQ10
  end

  always_comb begin
    step0 = dtc_step(mode0, u0_low, u0_high);
    step1 = dtc_step(mode1, u1_low, u1_high);
    split_lo = dtc_inc8(u0_low);
    split_hi = dtc_inc8(u0_high);
  end

  // count registers: software writes override the count step
  always_comb begin
    next_u0_low = u0_low;
    next_u0_high = u0_high;
    next_u1_low = u1_low;
    next_u1_high = u1_high;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    if (mode0 == DTC_SPLIT) begin
      if (inc0) begin
        next_u0_low = split_lo[7:0]; // RQ9
        ovf0 = split_lo[8]; // RQ10
      end
      if (inc0_high) begin
        next_u0_high = split_hi[7:0]; // RQ9
        ovf1 = split_hi[8]; // RQ10
      end
    end else if (inc0) begin
      {ovf0, next_u0_high, next_u0_low} = step0;
    end
    if (inc1) begin
      {next_u1_high, next_u1_low} = step1[15:0];
      // unit 1 flag belongs to the split high byte while unit 0 is split
      if (mode0 != DTC_SPLIT) begin
        ovf1 = step1[16]; // RQ10
      end
    end
    if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        ADDR_U0_LOW: next_u0_low = sfr_wdata_i;
        ADDR_U0_HIGH: next_u0_high = sfr_wdata_i;
        ADDR_U1_LOW: next_u1_low = sfr_wdata_i;
        ADDR_U1_HIGH: next_u1_high = sfr_wdata_i;
        default: ;
      endcase
    end
    if (mode0 == DTC_M13) begin
      next_u0_low[7:5] = 3'b000; // RQ6
    end
    if (mode1 == DTC_M13) begin
      next_u1_low[7:5] = 3'b000; // RQ6
    end
  end

  // control and mode: write, then service clear, then hardware set wins
  always_comb begin
    next_ctrl = ctrl;
    next_timer_mode_select = timer_mode_select;
    if (sfr_wr_i && (sfr_addr_i == ADDR_MODE)) begin
      next_timer_mode_select = sfr_wdata_i;
    end
    if (wr_ctrl) begin
      next_ctrl = sfr_wdata_i; // RQ15
    end
    if (unit0_ack_i) begin
      next_ctrl[CTRL_U0_OVF] = 1'b0; // RQ15
    end
    if (unit1_ack_i) begin
      next_ctrl[CTRL_U1_OVF] = 1'b0; // RQ15
    end
    if (ext_irq_a_ack_i) begin
      next_ctrl[CTRL_EXT_A_FLAG] = 1'b0; // RQ16
    end
    if (ext_irq_b_ack_i) begin
      next_ctrl[CTRL_EXT_B_FLAG] = 1'b0; // RQ16
    end
    if (ovf0) begin
      next_ctrl[CTRL_U0_OVF] = 1'b1; // RQ15
    end
    if (ovf1) begin
      next_ctrl[CTRL_U1_OVF] = 1'b1; // RQ15
    end
    if (evt.fall[PIN_IRQ_A]) begin
      next_ctrl[CTRL_EXT_A_FLAG] = 1'b1; // RQ16
    end
    if (evt.fall[PIN_IRQ_B]) begin
      next_ctrl[CTRL_EXT_B_FLAG] = 1'b1; // RQ16
    end
  end

  // registered read, unmapped addresses read zero
  always_comb begin
    unique case (sfr_addr_i)
      ADDR_CTRL: next_rdata = ctrl;
      ADDR_MODE: next_rdata = timer_mode_select;
      ADDR_U0_LOW: next_rdata = u0_low;
      ADDR_U1_LOW: next_rdata = u1_low;
      ADDR_U0_HIGH: next_rdata = u0_high;
      ADDR_U1_HIGH: next_rdata = u1_high;
      default: next_rdata = RDATA_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST; // RQ19
      timer_mode_select <= MODE_RST; // RQ19
      u0_low <= COUNT_RST; // RQ19
      u0_high <= COUNT_RST; // RQ19
      u1_low <= COUNT_RST; // RQ19
      u1_high <= COUNT_RST; // RQ19
      rdata <= RDATA_UNMAPPED;
    end else begin
      ctrl <= next_ctrl;
      timer_mode_select <= next_timer_mode_select;
      u0_low <= next_u0_low;
      u0_high <= next_u0_high;
      u1_low <= next_u1_low;
      u1_high <= next_u1_high;
      rdata <= next_rdata;
    end
  end

  assign sfr_rdata_o = rdata;
  assign unit0_irq_o = ctrl[CTRL_U0_OVF];
  assign unit1_irq_o = ctrl[CTRL_U1_OVF];
  // type 1 uses the edge flag, type 0 the sampled low level
  assign ext_irq_a_req_o = ctrl[CTRL_EXT_A_TYPE] ? ctrl[CTRL_EXT_A_FLAG] // RQ17 RQ18
                                                 : evt.level_low[PIN_IRQ_A];
  assign ext_irq_b_req_o = ctrl[CTRL_EXT_B_TYPE] ? ctrl[CTRL_EXT_B_FLAG] // RQ17 RQ18
                                                 : evt.level_low[PIN_IRQ_B];
endmodule // dtc_top
